// ===== include/sensor_pwr_pkg.sv
// constants for the image sensor power and standby sequencer
package sensor_pwr_pkg;
  // ------------------------------------------------------------------
  // timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 4000;
  localparam int REF_PERIOD_PS    = 40000;
  localparam int REF_HALF_CYCLES  = REF_PERIOD_PS / (2 * CLK_PERIOD_PS);
  localparam int QUIET_REF_CYCLES = 512;
  localparam int RAIL_OFF_NS      = 0;
  localparam int RAIL_OFF_CYCLES  = (RAIL_OFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [2:0] REF_HALF_LAST = 3'(REF_HALF_CYCLES - 1);
  // one edge more than the margin: the first edge may follow the transaction
  // at once, so 512 edges alone would span only 511 full periods
  localparam logic [9:0] QUIET_LAST    = 10'(QUIET_REF_CYCLES + 1);
  // ------------------------------------------------------------------
  // device register map
  // ------------------------------------------------------------------
  localparam logic [15:0] STANDBY_CONFIG_A_ADDR = 16'h30ab;
  localparam logic [15:0] STANDBY_CONFIG_B_ADDR = 16'h30ad;
  localparam logic [15:0] STANDBY_CONFIG_C_ADDR = 16'h30ae;
  localparam logic [15:0] STANDBY_CONFIG_D_ADDR = 16'h363b;
  localparam logic [15:0] REGULATOR_CTRL_ADDR   = 16'h3100;
  localparam logic [15:0] SLEEP_CTRL_ADDR       = 16'h0100;
  localparam logic [7:0]  STANDBY_CONFIG_A_VAL  = 8'h00;
  localparam logic [7:0]  STANDBY_CONFIG_B_VAL  = 8'h0a;
  localparam logic [7:0]  STANDBY_CONFIG_C_VAL  = 8'h27;
  localparam logic [7:0]  STANDBY_CONFIG_D_VAL  = 8'h01;
  localparam logic [7:0]  REGULATOR_OFF_VAL     = 8'h01;
  localparam logic [7:0]  SLEEP_ENTER_VAL       = 8'h00;
  localparam logic [7:0]  SLEEP_EXIT_VAL        = 8'h01;
  // ------------------------------------------------------------------
  // write list indices
  // ------------------------------------------------------------------
  localparam logic [2:0] WR_REGULATOR = 3'h0;
  localparam logic [2:0] WR_STBY_A    = 3'h1;
  localparam logic [2:0] WR_STBY_D    = 3'h4;
  localparam logic [2:0] WR_SLEEP     = 3'h5;
  localparam logic [2:0] WR_WAKE      = 3'h6;

  typedef enum logic [3:0] {
    ST_OFF     = 4'b0000,
    ST_RAIL_UP = 4'b0001,
    ST_PIN_UP  = 4'b0010,
    ST_CFG_WR  = 4'b0011,
    ST_ACTIVE  = 4'b0100,
    ST_SLP_WR  = 4'b0101,
    ST_SW_STBY = 4'b0110,
    ST_HS_WR   = 4'b0111,
    ST_HW_STBY = 4'b1000,
    ST_WAKE_WR = 4'b1001,
    ST_QUIET   = 4'b1010,
    ST_PIN_DN  = 4'b1011,
    ST_CORE_DN = 4'b1100,
    ST_IO_DN   = 4'b1101,
    ST_AN_DN   = 4'b1110
  } seq_state_t;
endpackage

// ===== logic/sensor_power_standby_sequencer.sv
// host-side power, standby and power-down sequencer for an image sensor
//
// Behaviour
// (RQ1) External core rail: drive regulator bypass pin at I/O level.
// (RQ2) External core rail: write regulator-off register after power-up.
// (RQ3) Only one of shutdown or powerdown pin is a GPIO; other follows I/O rail.
// (RQ4) Shutdown pin rises only after analog and I/O rails are good.
// (RQ5) Device offers pin-driven hardware standby and bus-driven software sleep.
// (RQ6) Hardware standby starts by writing 00 to config A, 0A to config B.
// (RQ7) Then write 27 to config C and 01 to config D.
// (RQ8) Then drive the active-high powerdown pin high.
// (RQ9) Device finishes current frame before entering software standby.
// (RQ10) Reference clock runs 512 cycles after last transaction or frame end.
// (RQ11) Shutdown pin falls no later than analog or I/O rail.
// (RQ12) Analog and I/O rails may fall in either order.
// (RQ13) Powerdown pin falls no later than the I/O rail.
// (RQ14) Shutdown pin falls no later than the external core rail; when tied to the I/O rail it falls one cycle after the core rail.
// (RQ15) External core rail falls no later than analog or I/O rail.
// (RQ16) Powerdown pin falls no later than the external core rail; when tied to the I/O rail it falls one cycle after the core rail.
// (RQ17) Shutdown-GPIO wiring: software standby first, then lower shutdown pin; power-down from active or hardware standby skips the sleep write.
// (RQ18) Powerdown-GPIO wiring: lower pin, then I/O rail, then analog rail.
// (RQ19) External core: pin low, then core rail off, then other rails.
// (RQ20) Every standby write must be acknowledged; a failure restarts the sequence.
`timescale 1ns/10ps
module sensor_power_standby_sequencer
(
  input  wire logic        clk_in,                 // 250 MHz system clock
  input  wire logic        sys_rst_in,             // synchronous reset, active high
  input  wire logic        ext_core_in,            // core rail supplied externally
  input  wire logic        gpio_is_powerdown_pin_in,        // 1: powerdown pin on GPIO, 0: shutdown pin
  input  wire logic        power_up_req_in,        // pulse: power up from off
  input  wire logic        power_down_req_in,      // pulse: power down to off
  input  wire logic        sw_standby_req_in,      // pulse: enter software sleep
  input  wire logic        hw_standby_req_in,      // pulse: enter hardware standby
  input  wire logic        wake_req_in,            // pulse: leave either standby
  input  wire logic        analog_rail_good_in,    // analog rail up (pin)
  input  wire logic        io_rail_good_in,        // I/O rail up (pin)
  input  wire logic        frame_end_in,           // end code seen on sensor output (pin)
  output logic             bus_wr_req_out,         // write request to control-bus master
  output logic [15:0]      bus_wr_addr_out,        // register address
  output logic [7:0]       bus_wr_data_out,        // register data
  input  wire logic        bus_wr_done_in,         // pulse: write finished
  input  wire logic        bus_wr_ack_in,          // with done: write acknowledged
  output logic             analog_rail_en_out,     // analog supply enable
  output logic             io_rail_en_out,         // I/O supply enable
  output logic             core_rail_en_out,       // external core supply enable
  output logic             regulator_bypass_pin_out, // regulator bypass pin
  output logic             shutdown_n_pin_out,     // shutdown pin, active low
  output logic             powerdown_n_pin_out,    // powerdown pin, active low
  output logic             powerdown_pin_out,      // hardware standby pin, active high
  output logic             reference_clock_out,    // reference clock to the sensor
  output sensor_pwr_pkg::seq_state_t state_out,    // current sequencer state
  output logic             write_fail_out          // pulse: a write was not acknowledged
);
  import sensor_pwr_pkg::*;

  // ------------------------------------------------------------------
  // synchronisers
  // ------------------------------------------------------------------
  logic [2:0] meta_sync;
  logic [2:0] stable_sync;
  logic       frame_prev;
  logic       analog_good;
  logic       io_good;
  logic       frame_end_edge;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      meta_sync   <= 3'h0;
      stable_sync <= 3'h0;
      frame_prev  <= 1'b0;
    end
    else
    begin
      meta_sync   <= {frame_end_in, io_rail_good_in, analog_rail_good_in};
      stable_sync <= meta_sync;
      frame_prev  <= stable_sync[2];
    end
  end

  assign analog_good    = stable_sync[0];
  assign io_good        = stable_sync[1];
  assign frame_end_edge = stable_sync[2] & ~frame_prev;

  // ------------------------------------------------------------------
  // reference clock divider
  // ------------------------------------------------------------------
  logic [2:0] ref_div;
  logic       ref_level;
  logic       ref_tick;
  logic       ref_run;

  assign ref_tick = ref_run & (ref_div == REF_HALF_LAST) & ~ref_level;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || !ref_run)
    begin
      ref_div   <= 3'h0;
      ref_level <= 1'b0;
    end
    else if (ref_div == REF_HALF_LAST)
    begin
      ref_div   <= 3'h0;
      ref_level <= ~ref_level;
    end
    else
    begin
      ref_div <= ref_div + 3'h1;
    end
  end

  // ------------------------------------------------------------------
  // quiet counter: reference cycles since last write or frame end
  // ------------------------------------------------------------------
  logic [9:0] quiet_cnt;
  logic       quiet_done;

  assign quiet_done = (quiet_cnt == QUIET_LAST);

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in || bus_wr_done_in || frame_end_edge)
      quiet_cnt <= 10'h000; // RQ10
    else if (ref_tick && !quiet_done)
      quiet_cnt <= quiet_cnt + 10'h001; // RQ10
  end

  // ------------------------------------------------------------------
  // write list
  // ------------------------------------------------------------------
  function automatic logic [23:0] wr_entry(input logic [2:0] idx);
    case (idx)
      WR_REGULATOR : wr_entry = {REGULATOR_CTRL_ADDR, REGULATOR_OFF_VAL};
      3'h1         : wr_entry = {STANDBY_CONFIG_A_ADDR, STANDBY_CONFIG_A_VAL};
      3'h2         : wr_entry = {STANDBY_CONFIG_B_ADDR, STANDBY_CONFIG_B_VAL};
      3'h3         : wr_entry = {STANDBY_CONFIG_C_ADDR, STANDBY_CONFIG_C_VAL};
      WR_STBY_D    : wr_entry = {STANDBY_CONFIG_D_ADDR, STANDBY_CONFIG_D_VAL};
      WR_SLEEP     : wr_entry = {SLEEP_CTRL_ADDR, SLEEP_ENTER_VAL};
      default      : wr_entry = {SLEEP_CTRL_ADDR, SLEEP_EXIT_VAL};
    endcase
  endfunction

  // ------------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------------
  seq_state_t state;
  logic [2:0] wr_idx;
  logic       ext_core;
  logic       gpio_powerdown_pin;
  logic       wr_ok;
  logic       wr_bad;

  assign wr_ok  = bus_wr_done_in & bus_wr_ack_in;
  assign wr_bad = bus_wr_done_in & ~bus_wr_ack_in;

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      state     <= ST_OFF;
      wr_idx    <= WR_REGULATOR;
      ext_core  <= 1'b0;
      gpio_powerdown_pin <= 1'b0;
    end
    else
    begin
      case (state)
        ST_OFF :
          if (power_up_req_in)
          begin
            // wiring is captured once per power cycle
            ext_core  <= ext_core_in;
            gpio_powerdown_pin <= gpio_is_powerdown_pin_in;
            state     <= ST_RAIL_UP;
          end
        ST_RAIL_UP :
          if (analog_good && io_good)
            state <= ST_PIN_UP; // RQ4
        ST_PIN_UP :
        begin
          wr_idx <= WR_REGULATOR;
          state  <= ext_core ? ST_CFG_WR : ST_ACTIVE; // RQ2
        end
        ST_CFG_WR :
          if (wr_ok)
            state <= ST_ACTIVE; // RQ2
        ST_ACTIVE :
          if (power_down_req_in)
            state <= ST_QUIET;
          else if (hw_standby_req_in)
          begin
            wr_idx <= WR_STBY_A; // RQ6
            state  <= ST_HS_WR;
          end
          else if (sw_standby_req_in)
          begin
            wr_idx <= WR_SLEEP; // RQ5
            state  <= ST_SLP_WR;
          end
        ST_SLP_WR :
          if (wr_ok)
            state <= ST_SW_STBY;
        ST_HS_WR :
          if (wr_bad)
            wr_idx <= WR_STBY_A; // RQ20
          else if (wr_ok && wr_idx == WR_STBY_D)
            state <= ST_HW_STBY; // RQ8
          else if (wr_ok)
            wr_idx <= wr_idx + 3'h1; // RQ7
        ST_SW_STBY,
        ST_HW_STBY :
          if (power_down_req_in)
            state <= ST_QUIET; // RQ17
          else if (wake_req_in)
          begin
            wr_idx <= WR_WAKE;
            state  <= ST_WAKE_WR;
          end
        ST_WAKE_WR :
          if (wr_ok)
            state <= ST_ACTIVE;
        ST_QUIET :
          if (quiet_done && !bus_wr_req_out)
            state <= ST_PIN_DN; // RQ10
        ST_PIN_DN :
          state <= ext_core ? ST_CORE_DN : ST_IO_DN; // RQ19
        ST_CORE_DN :
          state <= ST_IO_DN; // RQ15
        ST_IO_DN :
          state <= ST_AN_DN; // RQ18
        ST_AN_DN :
          state <= ST_OFF; // RQ12
        default :
          state <= ST_OFF;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------------
  logic in_write;
  logic pins_up;
  logic rails_on;
  logic io_on;

  assign in_write = (state == ST_CFG_WR) || (state == ST_SLP_WR) || (state == ST_HS_WR) || (state == ST_WAKE_WR);
  assign rails_on = (state != ST_OFF) && (state != ST_AN_DN);
  assign io_on    = rails_on && (state != ST_IO_DN);
  assign pins_up  = rails_on && (state != ST_RAIL_UP) && (state != ST_QUIET || !quiet_done)
                    && (state != ST_PIN_DN) && (state != ST_CORE_DN) && (state != ST_IO_DN);

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      bus_wr_req_out           <= 1'b0;
      bus_wr_addr_out          <= 16'h0000;
      bus_wr_data_out          <= 8'h00;
      analog_rail_en_out       <= 1'b0;
      io_rail_en_out           <= 1'b0;
      core_rail_en_out         <= 1'b0;
      regulator_bypass_pin_out <= 1'b0;
      shutdown_n_pin_out       <= 1'b0;
      powerdown_n_pin_out      <= 1'b0;
      powerdown_pin_out        <= 1'b0;
      reference_clock_out      <= 1'b0;
      ref_run                  <= 1'b0;
      state_out                <= ST_OFF;
      write_fail_out           <= 1'b0;
    end
    else
    begin
      // request drops in the cycle after done so no write is issued twice
      bus_wr_req_out           <= in_write && !bus_wr_done_in;
      {bus_wr_addr_out, bus_wr_data_out} <= wr_entry(wr_idx);
      analog_rail_en_out       <= rails_on; // RQ12
      io_rail_en_out           <= io_on; // RQ13
      core_rail_en_out         <= ext_core && rails_on && (state != ST_CORE_DN) && (state != ST_IO_DN); // RQ15
      regulator_bypass_pin_out <= ext_core && io_on; // RQ1
      // tied shutdown pin held low until both rails report good
      shutdown_n_pin_out       <= gpio_powerdown_pin ? (io_on && (state != ST_RAIL_UP)) : pins_up; // RQ3 RQ4 RQ11 RQ14
      powerdown_n_pin_out      <= gpio_powerdown_pin ? pins_up : io_on; // RQ3 RQ13 RQ16
      powerdown_pin_out        <= (state == ST_HW_STBY); // RQ8
      // clock stays on through the quiet wait
      ref_run                  <= rails_on && (state != ST_IO_DN); // RQ10
      reference_clock_out      <= ref_level;
      state_out                <= state;
      write_fail_out           <= wr_bad && in_write; // RQ20
    end
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  AST_BYPASS_WITH_CORE : assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ1
    core_rail_en_out |-> regulator_bypass_pin_out)
    else $error("core rail on without regulator bypass");
  AST_REG_OFF_WRITE : assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ2
    (state == ST_CFG_WR && wr_ok) |=> (state == ST_ACTIVE))
    else $error("regulator-off write not followed by active");
  AST_SHUTDOWN_AFTER_RAILS : assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ4
    $rose(shutdown_n_pin_out) |-> ($past(analog_good) && $past(io_good)))
    else $error("shutdown released before rails good");
  AST_STBY_FIRST_WRITE : assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ6
    (state == ST_ACTIVE && !power_down_req_in && hw_standby_req_in)
      |=> ##1 (bus_wr_addr_out == STANDBY_CONFIG_A_ADDR && bus_wr_data_out == STANDBY_CONFIG_A_VAL))
    else $error("hardware standby did not start with config A");
  AST_PIN_AFTER_WRITES : assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ8
    $rose(powerdown_pin_out) |-> $past(state, 2) == ST_HS_WR && $past(wr_idx, 2) == WR_STBY_D)
    else $error("powerdown pin raised without final write");
  AST_QUIET_BEFORE_SHUTDOWN : assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ10
    (state == ST_PIN_DN) |-> $past(quiet_done))
    else $error("shutdown lowered before 512 reference cycles");
  AST_PIN_BEFORE_RAIL : assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ11
    $fell(analog_rail_en_out) |-> !shutdown_n_pin_out && !powerdown_n_pin_out)
    else $error("rail fell while pin still high");
  AST_POWERDOWN_PIN_BEFORE_IO : assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ13
    !io_rail_en_out |-> !powerdown_n_pin_out && !shutdown_n_pin_out)
    else $error("pin high while I/O rail off");
  AST_CORE_BEFORE_RAILS : assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ15
    $fell(core_rail_en_out) |-> io_rail_en_out && analog_rail_en_out
      && !(gpio_powerdown_pin ? powerdown_n_pin_out : shutdown_n_pin_out))
    else $error("core rail order broken");
  AST_FAIL_RESTARTS : assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ20
    (state == ST_HS_WR && wr_bad) |=> (wr_idx == WR_STBY_A) && (state == ST_HS_WR))
    else $error("failed standby write did not restart sequence");
  AST_IO_BEFORE_ANALOG : assert property (@(posedge clk_in) disable iff (sys_rst_in) // RQ18
    $fell(io_rail_en_out) |=> $fell(analog_rail_en_out))
    else $error("analog rail did not follow I/O rail");

endmodule // sensor_power_standby_sequencer

// ===== test/sensor_device_model.sv
// behavioural image sensor: standby registers, write acks, rail status and frame ends
`timescale 1ns/10ps
module sensor_device_model
#(
  parameter int LAT = 3
)
(
  input  wire logic        clk_in,        // system clock
  input  wire logic        an_en_in,      // analog rail enable
  input  wire logic        io_en_in,      // I/O rail enable
  input  wire logic        pins_up_in,    // shutdown and powerdown pins released
  input  wire logic        stream_in,     // sensor set to stream frames
  input  wire logic        req_in,        // bus write request
  input  wire logic [15:0] addr_in,       // bus write address
  input  wire logic [7:0]  data_in,       // bus write data
  input  wire logic [3:0]  nacks_in,      // number of writes to refuse
  output logic             done_out,      // write finished
  output logic             ack_out,       // write acknowledged
  output logic             an_good_out,   // analog rail status
  output logic             io_good_out,   // I/O rail status
  output logic             frame_end_out  // end code of a frame
);
  import sensor_pwr_pkg::*;
  logic [7:0] cfg [4];
  logic       reg_off;
  logic       sleep_out;
  logic       pend;
  logic [3:0] wcnt;
  logic [3:0] ncnt;
  logic [7:0] fcnt;
  wire        streaming = stream_in && pins_up_in && !sleep_out;
  logic [3:0] an_ramp;
  logic [3:0] io_ramp;
  // supplies report good a few cycles after enable, as real rails would
  assign an_good_out   = an_en_in && an_ramp[3];
  assign io_good_out   = io_en_in && io_ramp[3];
  always @(posedge clk_in)
  begin
    an_ramp <= {an_ramp[2:0], an_en_in};
    io_ramp <= {io_ramp[2:0], io_en_in};
  end
  assign frame_end_out = streaming && (fcnt == 8'hff);
  // registers are lost with the I/O rail
  always @(posedge clk_in)
  begin
    if (!io_en_in)
    begin
      cfg      <= '{default: 8'h00};
      reg_off  <= 1'b0;
      sleep_out <= 1'b0;
      {pend, done_out, ack_out, wcnt, ncnt, fcnt} <= '0;
    end
    else
    begin
      done_out <= 1'b0;
      fcnt     <= streaming ? fcnt + 8'h01 : 8'h00;
      if (pend && (!streaming || frame_end_out))
      begin
        sleep_out <= 1'b1;
        pend      <= 1'b0;
      end
      if (!req_in || done_out)
        wcnt <= 4'h0;
      else if (wcnt == 4'(LAT))
      begin
        done_out <= 1'b1;
        ack_out  <= ncnt >= nacks_in;
        if (ncnt < nacks_in)
          ncnt <= ncnt + 4'h1;
        else
          case (addr_in)
            STANDBY_CONFIG_A_ADDR: cfg[0] <= data_in;
            STANDBY_CONFIG_B_ADDR: cfg[1] <= data_in;
            STANDBY_CONFIG_C_ADDR: cfg[2] <= data_in;
            STANDBY_CONFIG_D_ADDR: cfg[3] <= data_in;
            REGULATOR_CTRL_ADDR:   reg_off <= (data_in == REGULATOR_OFF_VAL);
            SLEEP_CTRL_ADDR:
            begin
              pend <= (data_in == SLEEP_ENTER_VAL);
              if (data_in != SLEEP_ENTER_VAL)
                sleep_out <= 1'b0;
            end
            default: ;
          endcase
      end
      else
        wcnt <= wcnt + 4'h1;
    end
  end
endmodule // sensor_device_model

// ===== test/sensor_power_standby_sequencer_tb.sv
// self-checking bench for the sensor power and standby sequencer
`timescale 1ns/10ps
module sensor_power_standby_sequencer_tb;
  import sensor_pwr_pkg::*;
  typedef struct packed {logic ext; logic pw;} row_t;
  logic        clk_in, sys_rst_in, ext_core_in, gpio_is_powerdown_pin_in, stream;
  logic        power_up_req_in, power_down_req_in, sw_standby_req_in, hw_standby_req_in, wake_req_in;
  logic        an_good, io_good, frame_end, bus_wr_done_in, bus_wr_ack_in, bus_wr_req_out;
  logic [15:0] bus_wr_addr_out;
  logic [7:0]  bus_wr_data_out;
  logic        analog_rail_en_out, io_rail_en_out, core_rail_en_out, regulator_bypass_pin_out;
  logic        shutdown_n_pin_out, powerdown_n_pin_out, powerdown_pin_out, reference_clock_out, write_fail_out;
  seq_state_t  state_out;
  logic [3:0]  nacks;
  int          num_errors, samples_checked, cyc, fails, i, t_done, t_sd, t_pd, t_core, t_io, t_an;
  row_t        rows [4] = '{2'b00, 2'b01, 2'b10, 2'b11};
  logic [7:0]  exp_cfg [4] = '{8'h00, 8'h0a, 8'h27, 8'h01};

  sensor_power_standby_sequencer dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ext_core_in(ext_core_in),
    .gpio_is_powerdown_pin_in(gpio_is_powerdown_pin_in), .power_up_req_in(power_up_req_in), .power_down_req_in(power_down_req_in),
    .sw_standby_req_in(sw_standby_req_in), .hw_standby_req_in(hw_standby_req_in), .wake_req_in(wake_req_in),
    .analog_rail_good_in(an_good), .io_rail_good_in(io_good), .frame_end_in(frame_end),
    .bus_wr_req_out(bus_wr_req_out), .bus_wr_addr_out(bus_wr_addr_out), .bus_wr_data_out(bus_wr_data_out),
    .bus_wr_done_in(bus_wr_done_in), .bus_wr_ack_in(bus_wr_ack_in), .analog_rail_en_out(analog_rail_en_out),
    .io_rail_en_out(io_rail_en_out), .core_rail_en_out(core_rail_en_out),
    .regulator_bypass_pin_out(regulator_bypass_pin_out), .shutdown_n_pin_out(shutdown_n_pin_out),
    .powerdown_n_pin_out(powerdown_n_pin_out), .powerdown_pin_out(powerdown_pin_out),
    .reference_clock_out(reference_clock_out), .state_out(state_out), .write_fail_out(write_fail_out));

  sensor_device_model dev (.clk_in(clk_in), .an_en_in(analog_rail_en_out), .io_en_in(io_rail_en_out),
    .pins_up_in(shutdown_n_pin_out && powerdown_n_pin_out && !powerdown_pin_out), .stream_in(stream),
    .req_in(bus_wr_req_out), .addr_in(bus_wr_addr_out), .data_in(bus_wr_data_out), .nacks_in(nacks),
    .done_out(bus_wr_done_in), .ack_out(bus_wr_ack_in), .an_good_out(an_good), .io_good_out(io_good),
    .frame_end_out(frame_end));

  initial
  begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // one-cycle command pulse: 0 up, 1 down, 2 sleep, 3 standby, 4 wake
  task cmd(input int k);
    @(negedge clk_in);
    {power_up_req_in, power_down_req_in, sw_standby_req_in, hw_standby_req_in, wake_req_in} = 5'b10000 >> k;
    @(negedge clk_in);
    {power_up_req_in, power_down_req_in, sw_standby_req_in, hw_standby_req_in, wake_req_in} = 5'b00000;
  endtask

  task wait_st(input seq_state_t s);
    int n;
    for (n = 0; n < 20000 && state_out !== s; n++)
      @(negedge clk_in);
    if (state_out !== s)
    begin
      num_errors++;
      $display("MISMATCH at %0t: state not reached", $time);
      wrap_up();
    end
  endtask

  // edge times of the supply and pin outputs
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (bus_wr_done_in) t_done <= cyc;
    if (write_fail_out) fails <= fails + 1;
    if ($fell(shutdown_n_pin_out)) t_sd <= cyc;
    if ($fell(powerdown_n_pin_out)) t_pd <= cyc;
    if ($fell(core_rail_en_out)) t_core <= cyc;
    if ($fell(io_rail_en_out)) t_io <= cyc;
    if ($fell(analog_rail_en_out)) t_an <= cyc;
    if ($rose(shutdown_n_pin_out)) chk(an_good && io_good, 1'b1);
  end

  initial
  begin
    {sys_rst_in, ext_core_in, gpio_is_powerdown_pin_in, stream, nacks} = 8'h80;
    {power_up_req_in, power_down_req_in, sw_standby_req_in, hw_standby_req_in, wake_req_in} = 5'b00000;
    {num_errors, samples_checked, cyc, fails} = '0;
    repeat (5) @(negedge clk_in);
    sys_rst_in = 1'b0;
    // ----------------------------------------------------------------
    // each wiring case: up, hardware standby, wake, down
    // ----------------------------------------------------------------
    foreach (rows[r])
    begin
      {ext_core_in, gpio_is_powerdown_pin_in} = rows[r];
      cmd(0);
      wait_st(ST_ACTIVE);
      chk(regulator_bypass_pin_out, rows[r].ext);
      chk(core_rail_en_out, rows[r].ext);
      chk(dev.reg_off, rows[r].ext);
      chk(shutdown_n_pin_out && powerdown_n_pin_out, 1'b1);
      for (i = 0; i < 12 && reference_clock_out !== 1'b1; i++) @(negedge clk_in);
      chk(reference_clock_out, 1'b1);
      cmd(3);
      wait_st(ST_HW_STBY);
      for (i = 0; i < 4; i++) chk(dev.cfg[i], exp_cfg[i]);
      chk(powerdown_pin_out, 1'b1);
      cmd(4);
      wait_st(ST_ACTIVE);
      chk(powerdown_pin_out, 1'b0);
      cmd(1);
      wait_st(ST_OFF);
      chk(t_sd - t_done >= QUIET_REF_CYCLES * REF_HALF_CYCLES * 2, 1'b1);
      if (!rows[r].pw) chk(t_sd <= t_io && t_sd <= t_an && t_sd < t_io, 1'b1);
      if (rows[r].pw) chk(t_pd <= t_io && t_io < t_an, 1'b1);
      if (rows[r].ext) chk(t_core <= t_io && t_core <= t_an && (rows[r].pw ? t_pd : t_sd) <= t_core, 1'b1);
      chk(reference_clock_out, 1'b0);
    end
    // ----------------------------------------------------------------
    // refused command, nacked writes, sleep while streaming, reset
    // ----------------------------------------------------------------
    {ext_core_in, gpio_is_powerdown_pin_in} = 2'b00;
    cmd(3);
    repeat (4) @(negedge clk_in);
    chk(state_out, ST_OFF);
    cmd(0);
    wait_st(ST_ACTIVE);
    nacks = 4'h2;
    fails = 0;
    cmd(3);
    wait_st(ST_HW_STBY);
    chk(fails, 2);
    for (i = 0; i < 4; i++) chk(dev.cfg[i], exp_cfg[i]);
    chk(powerdown_pin_out, 1'b1);
    cmd(4);
    wait_st(ST_ACTIVE);
    stream = 1'b1;
    cmd(2);
    wait_st(ST_SW_STBY);
    for (i = 0; i < 300 && dev.sleep_out !== 1'b1; i++) @(negedge clk_in);
    chk(dev.sleep_out, 1'b1);
    chk(shutdown_n_pin_out, 1'b1);
    cmd(4);
    wait_st(ST_ACTIVE);
    chk(dev.sleep_out, 1'b0);
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk({bus_wr_req_out, analog_rail_en_out, io_rail_en_out, core_rail_en_out, regulator_bypass_pin_out,
         shutdown_n_pin_out, powerdown_n_pin_out, powerdown_pin_out, reference_clock_out}, 9'h000);
    chk(state_out, ST_OFF);
    sys_rst_in = 1'b0;
    wrap_up();
  end
endmodule // sensor_power_standby_sequencer_tb
